// [rtl/dfp_cc_attach_detach.sv]
// Functional notes
// (R1) Both open: watch both pins, power off.
// (R2) Rd plus open: VBUS on, watch Rd.
// (R3) Ra plus open: watch both, VBUS off.
// (R4) Ra plus Rd: VBUS, VCONN on, watch Rd.
// (R5) Rd/Rd debug, Ra/Ra audio, power off.
// (R6) Per-pin two-bit pull-up current code.
// (R7) Config sampling diverts pull-up current away.
// (R8) Host access wakes device, starts oscillator.
// (R9) Software stops debouncer before reprogramming thresholds.
// (R10) Debouncer-running flag follows enabled sampling.
// (R11) Match valid after both pins debounced.
// (R12) Stable change updates result and change status.
// (R13) Enabled sources drive group irqs, IRQ low.
// (R14) VBUS result valid once VBUS threshold is enabled.
// (R15) Only enabled thresholds match and debounce.
// (R16) Software detects detach above open level.
// (R17) Keep-alive tick keeps sampling when clocks off.
// (R18) Software adds extra debounce after changes.
// (R19) VCONN on Ra pin, off on detach.
// (R20) Discharge switch closed until safe zero.
// (R21) Discharge timeout raises error, asserts IRQ.
// (R22) Baseband routed to the Rd pin.
// (R23) IRQ held while enabled pending source set.
`timescale 1ns/1ps
module dfp_cc_attach_detach
   import cc_det_pkg::*;
(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rstn,
   // Host side controls.
   input wire logic host_access,
   input wire logic keepalive_only,
   input wire logic [1:0] pin1_current_select,
   input wire logic [1:0] pin2_current_select,
   input wire logic cfg_sel_sampling,
   input wire logic [1:0] cc_sample_select,
   input wire logic cc_debounce_enable,
   input wire logic [DEB_W-1:0] cc_debounce_time,
   input wire logic [THR_W-1:0] pin1_threshold_enable,
   input wire logic [THR_W-1:0] pin2_threshold_enable,
   input wire logic [THR_W-1:0] pin1_debounce_clear_enable,
   input wire logic [THR_W-1:0] pin2_debounce_clear_enable,
   input wire logic [2:0] cc_irq_enable,
   input wire logic power_irq_enable,
   input wire logic discharge_irq_enable,
   input wire logic [1:0] irq_clear,
   input wire logic [2:0] cc_change_clear,
   input wire logic discharge_request,
   input wire logic [DEB_W-1:0] timeout_a,
   input wire logic vbus_threshold_enable,
   input wire logic pin1_vconn_request,
   input wire logic pin2_vconn_request,
   // Analog comparator inputs.
   input wire logic [THR_W-1:0] pin1_compare,
   input wire logic [THR_W-1:0] pin2_compare,
   input wire logic [1:0] pin1_term,
   input wire logic [1:0] pin2_term,
   input wire logic safe_zero_volt_hit,
   // Status.
   output logic osc_enable,
   output logic cc_debouncer_running,
   output logic cc_match_valid,
   output logic pin1_match_change,
   output logic pin2_match_change,
   output logic [THR_W-1:0] pin1_result,
   output logic [THR_W-1:0] pin2_result,
   output logic vbus_result_valid,
   output logic vbus_threshold_result,
   output logic discharge_error,
   output logic cc_group_irq,
   output logic power_group_irq,
   output logic irq_n,
   // Port drive.
   output logic [1:0] pin1_pullup,
   output logic [1:0] pin2_pullup,
   output logic vbus_on,
   output logic pin1_vconn_on,
   output logic pin2_vconn_on,
   output logic discharge_switch,
   output logic [1:0] watch_pins,
   output logic [1:0] comm_select,
   output logic [6:0] attach_state
);
   typedef struct packed {
      attach_e state;
      logic osc;
      logic [1:0] db_cnt;
      logic db_run;
      logic valid;
      logic chg1;
      logic chg2;
      logic vvalid;
      logic vres;
      logic derr;
      logic [DEB_W-1:0] dcnt;
      logic [KA_DIV_W-1:0] ka_cnt;
      logic tick;
      logic [1:0] pu1;
      logic [1:0] pu2;
      logic vbus;
      logic vc1;
      logic vc2;
      logic dsw;
      logic [1:0] watch;
      logic [1:0] comm;
      logic cc_irq;
      logic pwr_irq;
      logic irq_n;
   } top_s;
   top_s st_reg;
   top_s st_next;

   logic [THR_W-1:0] cmp1_s;
   logic [THR_W-1:0] cmp2_s;
   logic [1:0] term1_s;
   logic [1:0] term2_s;
   logic [1:0] misc_s;
   logic run1;
   logic run2;
   logic [THR_W-1:0] res1;
   logic [THR_W-1:0] res2;
   logic chp1;
   logic chp2;
   logic done1;
   logic done2;

   function automatic logic [1:0] pullup_code(input logic [1:0] sel, input logic divert);
      if (divert) begin
         pullup_code = RP_OFF; // [R7]
      end else begin
         case (sel)
            RP_DEFAULT, RP_MID, RP_HIGH: pullup_code = sel; // [R6]
            default: pullup_code = RP_OFF;
         endcase
      end
   endfunction : pullup_code

   function automatic attach_e classify(input logic [1:0] a, input logic [1:0] b);
      if (a == TERM_RD && b == TERM_RD) begin
         classify = ST_DEBUG; // [R5]
      end else if (a == TERM_RA && b == TERM_RA) begin
         classify = ST_AUDIO; // [R5]
      end else if ((a == TERM_RD) != (b == TERM_RD)) begin
         classify = (a == TERM_RA || b == TERM_RA) ? ST_CABLE_SINK : ST_SINK;
      end else if (a == TERM_RA || b == TERM_RA) begin
         classify = ST_CABLE; // [R3]
      end else begin
         classify = ST_NONE; // [R1]
      end
   endfunction : classify

   sync2 #(.W(THR_W)) u_sync_cmp1 (.sys_clk(sys_clk), .rstn(rstn), .d(pin1_compare), .q(cmp1_s));
   sync2 #(.W(THR_W)) u_sync_cmp2 (.sys_clk(sys_clk), .rstn(rstn), .d(pin2_compare), .q(cmp2_s));
   sync2 #(.W(2)) u_sync_t1 (.sys_clk(sys_clk), .rstn(rstn), .d(pin1_term), .q(term1_s));
   sync2 #(.W(2)) u_sync_t2 (.sys_clk(sys_clk), .rstn(rstn), .d(pin2_term), .q(term2_s));
   sync2 #(.W(2)) u_sync_misc (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .d({safe_zero_volt_hit, host_access}),
      .q(misc_s)
   );

   assign run1 = st_reg.db_run && cc_sample_select[0];
   assign run2 = st_reg.db_run && cc_sample_select[1];

   pin_debouncer u_deb1 (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .run(run1),
      .tick(st_reg.tick),
      .cc_debounce_time(cc_debounce_time),
      .pin_threshold_enable(pin1_threshold_enable),
      .pin_debounce_clear_enable(pin1_debounce_clear_enable),
      .raw_match(cmp1_s),
      .pin_threshold_result(res1),
      .change_pulse(chp1),
      .first_done(done1)
   );

   pin_debouncer u_deb2 (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .run(run2),
      .tick(st_reg.tick),
      .cc_debounce_time(cc_debounce_time),
      .pin_threshold_enable(pin2_threshold_enable),
      .pin_debounce_clear_enable(pin2_debounce_clear_enable),
      .raw_match(cmp2_s),
      .pin_threshold_result(res2),
      .change_pulse(chp2),
      .first_done(done2)
   );

   always_comb begin
      st_next = st_reg;
      // Any host access wakes the oscillator; keep-alive request stops it.
      if (misc_s[0]) begin
         st_next.osc = 1'b1; // [R8]
      end else if (keepalive_only) begin
         st_next.osc = 1'b0;
      end
      // Sampling is paced by the keep-alive tick, so it survives clock gating.
      if (st_reg.ka_cnt == KA_DIV_W'(KA_DIV - 1)) begin
         st_next.ka_cnt = '0;
         st_next.tick = 1'b1; // [R17]
      end else begin
         st_next.ka_cnt = st_reg.ka_cnt + 1'b1;
         st_next.tick = 1'b0;
      end
      // Debouncer runs shortly after sampling is enabled; stops at once when disabled.
      if (cc_debounce_enable && cc_sample_select != SAMP_NONE) begin
         if (st_reg.db_cnt == 2'(DB_ACTIVE_DELAY)) begin
            st_next.db_run = 1'b1; // [R10]
         end else begin
            st_next.db_cnt = st_reg.db_cnt + 1'b1;
         end
      end else begin
         st_next.db_cnt = '0;
         st_next.db_run = 1'b0; // [R9]
      end
      // Initial debounce of both pins gives match valid.
      st_next.valid = st_reg.db_run && done1 && done2; // [R11]
      // Change flags: set wins over clear.
      st_next.chg1 = chp1 || (st_reg.chg1 && !cc_change_clear[1]); // [R12]
      st_next.chg2 = chp2 || (st_reg.chg2 && !cc_change_clear[2]); // [R12]
      // VBUS result.
      st_next.vres = vbus_threshold_enable && misc_s[1];
      st_next.vvalid = vbus_threshold_enable; // [R14]
      // Pull-up drive.
      st_next.pu1 = pullup_code(pin1_current_select, cfg_sel_sampling); // [R6]
      st_next.pu2 = pullup_code(pin2_current_select, cfg_sel_sampling); // [R7]
      // Attach classification.
      case (st_reg.state)
         ST_DISCHARGE: begin
            if (misc_s[1]) begin
               st_next.state = ST_NONE;
               st_next.dsw = 1'b0; // [R20]
               st_next.dcnt = '0;
            end else if (st_reg.dcnt >= timeout_a) begin
               st_next.derr = 1'b1; // [R21]
            end else if (st_reg.tick) begin
               st_next.dcnt = st_reg.dcnt + 1'b1;
            end
         end
         default: begin
            st_next.state = classify(term1_s, term2_s);
            if (discharge_request && st_reg.vbus && !st_next.state[1] && !st_next.state[3]) begin
               st_next.state = ST_DISCHARGE;
               st_next.dsw = 1'b1; // [R20]
               st_next.dcnt = '0;
            end
         end
      endcase
      if (irq_clear[1]) begin
         st_next.derr = (st_reg.state == ST_DISCHARGE) && (st_reg.dcnt >= timeout_a) && !misc_s[1];
      end
      // Outputs derived from the state.
      st_next.vbus = 1'b0;
      st_next.vc1 = 1'b0;
      st_next.vc2 = 1'b0;
      st_next.watch = 2'b11; // [R1]
      st_next.comm = 2'b00;
      case (st_next.state)
         ST_SINK: begin
            st_next.vbus = 1'b1; // [R2]
            st_next.watch = (term1_s == TERM_RD) ? 2'b01 : 2'b10; // [R2]
            st_next.comm = st_next.watch; // [R22]
         end
         ST_CABLE: begin
            st_next.watch = 2'b11; // [R3]
            st_next.vc1 = pin1_vconn_request && term1_s == TERM_RA; // [R19]
            st_next.vc2 = pin2_vconn_request && term2_s == TERM_RA; // [R19]
         end
         ST_CABLE_SINK: begin
            st_next.vbus = 1'b1; // [R4]
            st_next.watch = (term1_s == TERM_RD) ? 2'b01 : 2'b10; // [R4]
            st_next.comm = st_next.watch; // [R22]
            st_next.vc1 = term1_s == TERM_RA; // [R4]
            st_next.vc2 = term2_s == TERM_RA; // [R4]
         end
         ST_DEBUG, ST_AUDIO: st_next.watch = 2'b11; // [R5]
         ST_DISCHARGE: st_next.watch = 2'b00;
         default: st_next.watch = 2'b11;
      endcase
      // Group interrupts and pin.
      st_next.cc_irq = (cc_irq_enable[0] && st_next.valid) || (cc_irq_enable[1] && st_next.chg1)
         || (cc_irq_enable[2] && st_next.chg2); // [R13]
      st_next.pwr_irq = (power_irq_enable && st_next.vvalid) || (discharge_irq_enable && st_next.derr); // [R21]
      st_next.irq_n = !(st_next.cc_irq || st_next.pwr_irq); // [R23]
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= '0;
         st_reg.state <= ST_NONE;
         st_reg.osc <= 1'b1;
         st_reg.watch <= 2'b11;
         st_reg.irq_n <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign osc_enable = st_reg.osc;
   assign cc_debouncer_running = st_reg.db_run;
   assign cc_match_valid = st_reg.valid;
   assign pin1_match_change = st_reg.chg1;
   assign pin2_match_change = st_reg.chg2;
   assign pin1_result = res1;
   assign pin2_result = res2;
   assign vbus_result_valid = st_reg.vvalid;
   assign vbus_threshold_result = st_reg.vres;
   assign discharge_error = st_reg.derr;
   assign cc_group_irq = st_reg.cc_irq;
   assign power_group_irq = st_reg.pwr_irq;
   assign irq_n = st_reg.irq_n;
   assign pin1_pullup = st_reg.pu1;
   assign pin2_pullup = st_reg.pu2;
   assign vbus_on = st_reg.vbus;
   assign pin1_vconn_on = st_reg.vc1;
   assign pin2_vconn_on = st_reg.vc2;
   assign discharge_switch = st_reg.dsw;
   assign watch_pins = st_reg.watch;
   assign comm_select = st_reg.comm;
   assign attach_state = st_reg.state;
endmodule : dfp_cc_attach_detach

// [rtl/cc_det_pkg.sv]
package cc_det_pkg;
   // Pull-up current codes.
   localparam logic [1:0] RP_OFF = 2'h0;
   localparam logic [1:0] RP_DEFAULT = 2'h1;
   localparam logic [1:0] RP_MID = 2'h2;
   localparam logic [1:0] RP_HIGH = 2'h3;
   // Comparator sampling select.
   localparam logic [1:0] SAMP_NONE = 2'h0;
   localparam logic [1:0] SAMP_PIN1 = 2'h1;
   localparam logic [1:0] SAMP_PIN2 = 2'h2;
   localparam logic [1:0] SAMP_BOTH = 2'h3;
   // Threshold field layout.
   localparam int THR_W = 8;
   localparam int DEB_W = 16;
   // Clock and timing.
   localparam int SYS_CLK_HZ = 20000000;
   localparam int KA_CLK_HZ = 20000;
   localparam int KA_DIV = SYS_CLK_HZ / KA_CLK_HZ;
   localparam int KA_DIV_W = 10;
   localparam int DB_ACTIVE_DELAY = 2;
   // Termination seen on a pin.
   typedef enum logic [1:0] {
      TERM_OPEN = 2'h0,
      TERM_RD = 2'h1,
      TERM_RA = 2'h2
   } term_e;
   // Attach states, one-hot.
   typedef enum logic [6:0] {
      ST_NONE = 7'h01,
      ST_SINK = 7'h02,
      ST_CABLE = 7'h04,
      ST_CABLE_SINK = 7'h08,
      ST_DEBUG = 7'h10,
      ST_AUDIO = 7'h20,
      ST_DISCHARGE = 7'h40
   } attach_e;
endpackage : cc_det_pkg

// [rtl/pin_debouncer.sv]
`timescale 1ns/1ps
module pin_debouncer
   import cc_det_pkg::*;
(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rstn,
   // Control.
   input wire logic run,
   input wire logic tick,
   input wire logic [DEB_W-1:0] cc_debounce_time,
   input wire logic [THR_W-1:0] pin_threshold_enable,
   input wire logic [THR_W-1:0] pin_debounce_clear_enable,
   input wire logic [THR_W-1:0] raw_match,
   // Results.
   output logic [THR_W-1:0] pin_threshold_result,
   output logic change_pulse,
   output logic first_done
);
   typedef struct packed {
      logic [THR_W-1:0] result;
      logic [DEB_W-1:0] count;
      logic chg;
      logic done;
   } deb_s;
   deb_s st_reg;
   deb_s st_next;
   logic [THR_W-1:0] gated;

   always_comb begin
      st_next = st_reg;
      st_next.chg = 1'b0;
      gated = raw_match & pin_threshold_enable & pin_debounce_clear_enable; // [R15]
      if (!run) begin
         st_next.count = '0;
         st_next.done = 1'b0;
      end else if (gated == st_reg.result && st_reg.done) begin
         st_next.count = '0;
      end else if (tick) begin
         if (st_reg.count >= cc_debounce_time) begin
            st_next.count = '0;
            st_next.chg = (gated != st_reg.result); // [R12]
            st_next.result = gated; // [R12]
            st_next.done = 1'b1;
         end else begin
            st_next.count = st_reg.count + 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign pin_threshold_result = st_reg.result;
   assign change_pulse = st_reg.chg;
   assign first_done = st_reg.done;
endmodule : pin_debouncer

// [rtl/sync2.sv]
`timescale 1ns/1ps
module sync2 #(
   parameter int W = 1
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rstn,
   // Data.
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_s;
   sync_s st_reg;
   sync_s st_next;

   always_comb begin
      st_next.s1 = d;
      st_next.s2 = st_reg.s1;
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign q = st_reg.s2;
endmodule : sync2

// [test/cc_partner_model.sv]
`timescale 1ns/1ps
module cc_partner_model
   import cc_det_pkg::*;
(
   // Clock and scenario control.
   input wire logic sys_clk,
   input wire logic [1:0] cc1_kind,
   input wire logic [1:0] cc2_kind,
   input wire logic stuck,
   // Device side.
   input wire logic vbus_on,
   input wire logic discharge_switch,
   output logic [1:0] pin1_term,
   output logic [1:0] pin2_term,
   output logic [THR_W-1:0] pin1_compare,
   output logic [THR_W-1:0] pin2_compare,
   output logic safe_zero_volt_hit
);
   logic [5:0] level_reg = 6'h00;
   // An Rd pin trips only the attach level; an open pin also trips the open level.
   function automatic logic [THR_W-1:0] lvl(input logic [1:0] k);
      return (k == TERM_RD) ? 8'h08 : ((k == TERM_OPEN) ? 8'h48 : 8'h00);
   endfunction : lvl
   assign pin1_term = cc1_kind;
   assign pin2_term = cc2_kind;
   assign pin1_compare = lvl(cc1_kind);
   assign pin2_compare = lvl(cc2_kind);
   assign safe_zero_volt_hit = (level_reg == 6'h00);
   // VBUS bleeds down only through the discharge switch, unless held up on purpose.
   always @(posedge sys_clk) begin
      if (vbus_on) begin
         level_reg <= 6'h32;
      end else if (discharge_switch && !stuck && level_reg != 6'h00) begin
         level_reg <= level_reg - 6'h01;
      end
   end
endmodule : cc_partner_model

// [test/dfp_cc_attach_detach_monitor.sv]
`timescale 1ns/1ps
module dfp_cc_attach_detach_monitor
   import cc_det_pkg::*;
(
   // Clock and inputs.
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic cfg_sel_sampling,
   input wire logic cc_debounce_enable,
   input wire logic [1:0] cc_sample_select,
   input wire logic [1:0] pin1_term,
   input wire logic [1:0] pin2_term,
   input wire logic safe_zero_volt_hit,
   // Outputs.
   input wire logic [1:0] pin1_pullup,
   input wire logic [1:0] pin2_pullup,
   input wire logic vbus_on,
   input wire logic pin1_vconn_on,
   input wire logic [1:0] watch_pins,
   input wire logic [1:0] comm_select,
   input wire logic [6:0] attach_state,
   input wire logic discharge_switch,
   input wire logic cc_debouncer_running,
   input wire logic cc_match_valid,
   input wire logic cc_group_irq,
   input wire logic power_group_irq,
   input wire logic irq_n
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);
   sequence s_rd_open;
      (pin1_term == TERM_RD && pin2_term == TERM_OPEN)[*5];
   endsequence
   sequence s_ra_rd;
      (pin1_term == TERM_RA && pin2_term == TERM_RD)[*5];
   endsequence
   sequence s_sampling;
      (cc_debounce_enable && cc_sample_select != SAMP_NONE)[*4];
   endsequence
   sequence s_drained;
      discharge_switch && safe_zero_volt_hit ##1 safe_zero_volt_hit[*4];
   endsequence
   property p_rp_off;
      cfg_sel_sampling[*5] |-> pin1_pullup == 2'h0 && pin2_pullup == 2'h0;
   endproperty
   property p_sink;
      s_rd_open |-> vbus_on && !pin1_vconn_on && watch_pins == 2'h1 && comm_select == 2'h1 && attach_state == 7'h02;
   endproperty
   property p_cable_sink;
      s_ra_rd |-> vbus_on && pin1_vconn_on && watch_pins == 2'h2 && comm_select == 2'h2;
   endproperty
   property p_accessory;
      (pin1_term == pin2_term && (pin1_term == TERM_RD || pin1_term == TERM_RA) && !discharge_switch)[*5]
      |-> !vbus_on && watch_pins == 2'h3 && attach_state == ((pin1_term == TERM_RD) ? 7'h10 : 7'h20);
   endproperty
   property p_db_run;
      s_sampling |-> cc_debouncer_running;
   endproperty
   property p_valid;
      $rose(cc_match_valid) |-> $past(cc_debouncer_running);
   endproperty
   property p_irq;
      (cc_group_irq || power_group_irq)[*2] |-> !irq_n;
   endproperty
   property p_drain;
      s_drained |-> !discharge_switch;
   endproperty
   a_rp_off: assert property (p_rp_off) else $error("pull-up not diverted");
   a_sink: assert property (p_sink) else $error("sink attach outputs wrong");
   a_cable_sink: assert property (p_cable_sink) else $error("cable with sink outputs wrong");
   a_accessory: assert property (p_accessory) else $error("accessory outputs wrong");
   a_db_run: assert property (p_db_run) else $error("debouncer flag missing");
   a_valid: assert property (p_valid) else $error("match valid without debouncer");
   a_irq: assert property (p_irq) else $error("irq pin not asserted");
   a_drain: assert property (p_drain) else $error("discharge switch left closed");
endmodule : dfp_cc_attach_detach_monitor

bind dfp_cc_attach_detach dfp_cc_attach_detach_monitor mon (.sys_clk, .rstn, .cfg_sel_sampling,
   .cc_debounce_enable, .cc_sample_select, .pin1_term, .pin2_term, .safe_zero_volt_hit, .pin1_pullup,
   .pin2_pullup, .vbus_on, .pin1_vconn_on, .watch_pins, .comm_select, .attach_state, .discharge_switch,
   .cc_debouncer_running, .cc_match_valid, .cc_group_irq, .power_group_irq, .irq_n);

// [test/dfp_cc_attach_detach_tb.sv]
`timescale 1ns/1ps
module dfp_cc_attach_detach_tb
   import cc_det_pkg::*;
;
   logic sys_clk = 1'b0, rstn = 1'b0, stuck = 1'b0;
   logic host_access, keepalive_only, cfg_sel_sampling, cc_debounce_enable, power_irq_enable;
   logic discharge_irq_enable, discharge_request, vbus_threshold_enable, pin1_vconn_request, pin2_vconn_request;
   logic [1:0] pin1_current_select, pin2_current_select, cc_sample_select, irq_clear, cc1_kind, cc2_kind;
   logic [2:0] cc_irq_enable, cc_change_clear;
   logic [DEB_W-1:0] cc_debounce_time, timeout_a;
   logic [THR_W-1:0] pin1_threshold_enable, pin2_threshold_enable, pin1_debounce_clear_enable;
   logic [THR_W-1:0] pin2_debounce_clear_enable, pin1_compare, pin2_compare, pin1_result, pin2_result;
   logic [1:0] pin1_term, pin2_term, pin1_pullup, pin2_pullup, watch_pins, comm_select;
   logic safe_zero_volt_hit, osc_enable, cc_debouncer_running, cc_match_valid, pin1_match_change;
   logic pin2_match_change, vbus_result_valid, vbus_threshold_result, discharge_error, cc_group_irq;
   logic power_group_irq, irq_n, vbus_on, pin1_vconn_on, pin2_vconn_on, discharge_switch;
   logic [6:0] attach_state;
   int num_errors = 0, comparisons = 0, i;

   dfp_cc_attach_detach DUT (.sys_clk, .rstn, .host_access, .keepalive_only, .pin1_current_select,
      .pin2_current_select, .cfg_sel_sampling, .cc_sample_select, .cc_debounce_enable, .cc_debounce_time,
      .pin1_threshold_enable, .pin2_threshold_enable, .pin1_debounce_clear_enable, .pin2_debounce_clear_enable,
      .cc_irq_enable, .power_irq_enable, .discharge_irq_enable, .irq_clear, .cc_change_clear, .discharge_request,
      .timeout_a, .vbus_threshold_enable, .pin1_vconn_request, .pin2_vconn_request, .pin1_compare, .pin2_compare,
      .pin1_term, .pin2_term, .safe_zero_volt_hit, .osc_enable, .cc_debouncer_running, .cc_match_valid,
      .pin1_match_change, .pin2_match_change, .pin1_result, .pin2_result, .vbus_result_valid,
      .vbus_threshold_result, .discharge_error, .cc_group_irq, .power_group_irq, .irq_n, .pin1_pullup,
      .pin2_pullup, .vbus_on, .pin1_vconn_on, .pin2_vconn_on, .discharge_switch, .watch_pins, .comm_select,
      .attach_state);
   cc_partner_model sink (.sys_clk, .cc1_kind, .cc2_kind, .stuck, .vbus_on, .discharge_switch, .pin1_term,
      .pin2_term, .pin1_compare, .pin2_compare, .safe_zero_volt_hit);

   always #25 sys_clk = ~sys_clk;

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : cyc

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : give_verdict

   task automatic set_terms(input logic [1:0] a, input logic [1:0] b);
      @(posedge sys_clk);
      cc1_kind <= a;
      cc2_kind <= b;
      cyc(6);
   endtask : set_terms

   task automatic attach(input logic [1:0] a, input logic [1:0] b, input logic vb, input logic [1:0] vc,
      input logic [1:0] w, input logic [1:0] cm, input logic [6:0] st);
      set_terms(a, b);
      chk(attach_state, st);
      chk(vbus_on, vb);
      chk({pin2_vconn_on, pin1_vconn_on}, vc);
      chk(watch_pins, w);
      if (vb) begin
         chk(comm_select, cm);
      end
      set_terms(TERM_OPEN, TERM_OPEN);
      chk(attach_state, 7'h01);
      chk({pin2_vconn_on, pin1_vconn_on, vbus_on}, 3'h0);
   endtask : attach

   initial begin
      {host_access, keepalive_only, cfg_sel_sampling, cc_debounce_enable, power_irq_enable} = 5'h00;
      {discharge_irq_enable, discharge_request, vbus_threshold_enable, pin2_vconn_request} = 4'h0;
      pin1_vconn_request = 1'b1;
      {pin1_current_select, pin2_current_select, cc_sample_select, irq_clear} = 8'h00;
      {cc_irq_enable, cc_change_clear} = 6'h00;
      cc_debounce_time = 16'h0001;
      timeout_a = 16'h0002;
      {pin1_threshold_enable, pin1_debounce_clear_enable} = 16'h4848;
      {pin2_threshold_enable, pin2_debounce_clear_enable} = 16'h0808;
      cc1_kind = TERM_OPEN;
      cc2_kind = TERM_OPEN;
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      cyc(6);
      chk({attach_state, watch_pins}, 9'h007);
      for (i = 0; i < 4; i++) begin
         @(posedge sys_clk);
         pin1_current_select <= i[1:0];
         pin2_current_select <= 2'h3 - i[1:0];
         cyc(5);
         chk({pin1_pullup, pin2_pullup}, {i[1:0], 2'h3 - i[1:0]});
      end
      @(posedge sys_clk);
      cfg_sel_sampling <= 1'b1;
      cyc(6);
      chk({pin1_pullup, pin2_pullup}, 4'h0);
      @(posedge sys_clk) cfg_sel_sampling <= 1'b0;
      keepalive_only <= 1'b1;
      cyc(6);
      chk({osc_enable, pin1_pullup}, 3'h3);
      @(posedge sys_clk) host_access <= 1'b1;
      cyc(6);
      chk(osc_enable, 1'b1);
      $display("test pull-up and wake done");
      attach(TERM_RD, TERM_OPEN, 1'b1, 2'h0, 2'h1, 2'h1, 7'h02);
      attach(TERM_OPEN, TERM_RD, 1'b1, 2'h0, 2'h2, 2'h2, 7'h02);
      attach(TERM_RA, TERM_OPEN, 1'b0, 2'h1, 2'h3, 2'h0, 7'h04);
      attach(TERM_OPEN, TERM_RA, 1'b0, 2'h0, 2'h3, 2'h0, 7'h04);
      attach(TERM_RA, TERM_RD, 1'b1, 2'h1, 2'h2, 2'h2, 7'h08);
      attach(TERM_RD, TERM_RA, 1'b1, 2'h2, 2'h1, 2'h1, 7'h08);
      attach(TERM_RD, TERM_RD, 1'b0, 2'h0, 2'h3, 2'h0, 7'h10);
      attach(TERM_RA, TERM_RA, 1'b0, 2'h0, 2'h3, 2'h0, 7'h20);
      $display("test attach table done");
      chk(cc_debouncer_running, 1'b0);
      @(posedge sys_clk);
      host_access <= 1'b0;
      cc_irq_enable <= 3'h7;
      cc_sample_select <= SAMP_BOTH;
      cc_debounce_enable <= 1'b1;
      cyc(4);
      chk({cc_debouncer_running, osc_enable}, 2'h2);
      for (i = 0; i < 20000 && cc_match_valid !== 1'b1; i++) cyc(1);
      chk({cc_match_valid, pin1_result, pin2_result}, 17'h14808);
      cyc(3);
      chk({cc_group_irq, irq_n}, 2'h2);
      @(posedge sys_clk);
      cc_irq_enable <= 3'h6;
      cc_change_clear <= 3'h6;
      cc1_kind <= TERM_RD;
      cc2_kind <= TERM_RD;
      cyc(3);
      chk({pin1_match_change, pin2_match_change}, 2'h0);
      @(posedge sys_clk) cc_change_clear <= 3'h0;
      for (i = 0; i < 20000 && pin1_match_change !== 1'b1; i++) cyc(1);
      cyc(20);
      chk({pin1_result, pin2_match_change, pin2_result}, 17'h01008);
      chk({cc_group_irq, irq_n}, 2'h2);
      @(posedge sys_clk) cc_change_clear <= 3'h2;
      cyc(3);
      @(posedge sys_clk) cc_change_clear <= 3'h0;
      cyc(3);
      chk({pin1_match_change, cc_group_irq, irq_n}, 3'h1);
      @(posedge sys_clk) vbus_threshold_enable <= 1'b1;
      power_irq_enable <= 1'b1;
      cyc(6);
      chk({vbus_result_valid, vbus_threshold_result, power_group_irq, irq_n}, 4'ha);
      @(posedge sys_clk) {vbus_threshold_enable, power_irq_enable, cc_debounce_enable} <= 3'h0;
      cyc(6);
      chk({irq_n, cc_debouncer_running}, 2'h2);
      $display("test debounce and irq done");
      @(posedge sys_clk) host_access <= 1'b1;
      discharge_request <= 1'b1;
      discharge_irq_enable <= 1'b1;
      set_terms(TERM_OPEN, TERM_OPEN);
      set_terms(TERM_RD, TERM_OPEN);
      set_terms(TERM_OPEN, TERM_OPEN);
      chk({attach_state, discharge_switch}, 8'h81);
      cyc(60);
      chk({discharge_switch, discharge_error}, 2'h0);
      stuck <= 1'b1;
      set_terms(TERM_RD, TERM_OPEN);
      set_terms(TERM_OPEN, TERM_OPEN);
      cyc(900);
      chk({discharge_switch, discharge_error}, 2'h2);
      for (i = 0; i < 4000 && discharge_error !== 1'b1; i++) cyc(1);
      cyc(3);
      chk({discharge_error, irq_n}, 2'h2);
      @(posedge sys_clk) irq_clear <= 2'h2;
      cyc(3);
      chk(discharge_error, 1'b1);
      $display("test discharge done");
      give_verdict();
   end

   initial begin
      repeat (60000) @(posedge sys_clk);
      num_errors++;
      $display("watchdog expired at %0t", $time);
      give_verdict();
   end
endmodule : dfp_cc_attach_detach_tb
